//--- src/gpd_pkg.sv
// package for the debounced general purpose pin port: register map, fields,
// commands, reset values and timing constants.
// assumes a 200 MHz system clock and a 32-bit apb register bus.
package gpd_pkg;

  // register byte offsets on the apb bus
  localparam logic [11:0] GPD_CMD_OFS  = 12'h000;  // command register, write only
  localparam logic [11:0] GPD_STAT_OFS = 12'h004;  // status of the last command
  localparam logic [11:0] GPD_VIEW_OFS = 12'h008;  // state of the last addressed pin

  // command register fields
  localparam int GPD_CMD_PIN_LSB = 0;   // pin index, 8 bits
  localparam int GPD_CMD_OP_LSB  = 8;   // operation code, 3 bits
  localparam int GPD_CMD_MS_LSB  = 16;  // debounce interval in ms, 16 bits

  // status register bit positions
  localparam int GPD_ST_BUSY = 0;  // command in progress
  localparam int GPD_ST_RES  = 1;  // result bit of sample or key read
  localparam int GPD_ST_ERR  = 2;  // last key read had an illegal interval
  localparam int GPD_ST_DONE = 3;  // last command has completed

  // view register bit positions
  localparam int GPD_VW_OE  = 8;   // output enable of the viewed pin
  localparam int GPD_VW_OUT = 9;   // output level of the viewed pin
  localparam int GPD_VW_LVL = 10;  // synchronised level of the viewed pin

  // pin operations
  localparam logic [2:0] GPD_OP_INPUT = 3'h0;  // high impedance input
  localparam logic [2:0] GPD_OP_HIGH  = 3'h1;  // output, drive high
  localparam logic [2:0] GPD_OP_LOW   = 3'h2;  // output, drive low
  localparam logic [2:0] GPD_OP_SAMP  = 3'h3;  // switch to input and sample
  localparam logic [2:0] GPD_OP_KEYL  = 3'h4;  // debounced read, low active
  localparam logic [2:0] GPD_OP_KEYH  = 3'h5;  // debounced read, high active

  // reset values
  localparam logic [255:0] GPD_OE_RST  = 256'h0;  // every pin high impedance
  localparam logic [255:0] GPD_OUT_RST = 256'h0;  // output latches low

  // timing
  localparam int GPD_CLK_PS  = 5000;        // system clock period in ps
  localparam int GPD_TICK_US = 1000;        // debounce tick, 1 ms in us
  // us to ps before dividing by the clock period in ps
  localparam int GPD_TICK_CYC = (GPD_TICK_US * 1000 * 1000) / GPD_CLK_PS;  // 200000
  localparam logic [1:0] GPD_SETTLE_CYC = 2'h3;  // synchroniser settle time

  // command sequencer states
  typedef enum logic [1:0] {
    GPD_IDLE,
    GPD_SETTLE,
    GPD_DEBOUNCE
  } gpd_state_t;

endpackage

//--- src/gpd_port.sv
// debounced general purpose pin port with 256 pins behind an apb slave.
// assumes pin inputs are asynchronous, the apb master is on sys_clk and the
// pad ring resolves each pin from pin_out and pin_oe.
`timescale 1ns/1ps
`default_nettype none

module gpd_port
  import gpd_pkg::*;
#(
  parameter int MS_CYCLES = GPD_TICK_CYC  // cycles per ms, shorten in simulation
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic [255:0] pin_in,
  output logic      [255:0] pin_out,
  output logic      [255:0] pin_oe
);

  // true when the level counts as a pressed key for the chosen polarity
  function automatic logic key_active(input logic lvl, input logic high_act);
    key_active = high_act ? lvl : ~lvl;
  endfunction

  // pin synchronisers
  logic [255:0] sync1_r;       // first stage, read only by sync2_r
  logic [255:0] sync2_r;       // synchronised pin levels

  // pin control
  logic [255:0] oe_r;          // output enables
  logic [255:0] oe_nxt;
  logic [255:0] out_r;         // output levels
  logic [255:0] out_nxt;

  // command sequencer
  gpd_state_t   state_r;       // sequencer state
  gpd_state_t   state_nxt;
  logic [7:0]   pin_r;         // pin of the current or last command
  logic [7:0]   pin_nxt;
  logic [2:0]   op_r;          // operation being carried out
  logic [2:0]   op_nxt;
  logic [15:0]  ms_left_r;     // whole ms still to wait
  logic [15:0]  ms_left_nxt;
  logic [31:0]  tick_cnt_r;    // cycles within the current ms
  logic [31:0]  tick_cnt_nxt;
  logic [1:0]   settle_r;      // settle countdown
  logic [1:0]   settle_nxt;
  logic         res_r;         // result bit
  logic         res_nxt;
  logic         err_r;         // illegal interval seen
  logic         err_nxt;
  logic         done_r;        // last command completed
  logic         done_nxt;

  // apb answer
  logic [31:0]  prdata_r;
  logic [31:0]  prdata_nxt;
  logic         pready_r;
  logic         pready_nxt;
  logic         pslverr_r;
  logic         pslverr_nxt;

  // decoded request
  logic         setup_phase;   // setup cycle of a transfer
  logic         cmd_wr;        // accepted command write
  logic         busy;          // sequencer not idle
  logic         lvl;           // synchronised level of the current pin
  logic         ms_tick;       // last cycle of a millisecond

  assign setup_phase = psel & ~penable;
  assign busy        = (state_r != GPD_IDLE);
  assign lvl         = sync2_r[pin_r];
  assign ms_tick     = (tick_cnt_r == 32'(MS_CYCLES - 1));
  // commands are taken in the setup cycle; the answer follows one cycle later
  assign cmd_wr      = setup_phase & pwrite & (paddr == GPD_CMD_OFS) & ~busy;

  // two flops before any logic looks at a pin
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sync1_r <= 256'h0;
      sync2_r <= 256'h0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // sequencer and pin control next state
  always_comb begin
    state_nxt    = state_r;
    oe_nxt       = oe_r;
    out_nxt      = out_r;
    pin_nxt      = pin_r;
    op_nxt       = op_r;
    ms_left_nxt  = ms_left_r;
    tick_cnt_nxt = tick_cnt_r;
    settle_nxt   = settle_r;
    res_nxt      = res_r;
    err_nxt      = err_r;
    done_nxt     = done_r;
    unique case (state_r)
      GPD_IDLE: begin
        if (cmd_wr) begin
          // full 8-bit index, every value is a legal pin
          pin_nxt      = pwdata[GPD_CMD_PIN_LSB +: 8];
          op_nxt       = pwdata[GPD_CMD_OP_LSB +: 3];
          ms_left_nxt  = pwdata[GPD_CMD_MS_LSB +: 16];  // interval in ms
          tick_cnt_nxt = 32'h0;
          settle_nxt   = GPD_SETTLE_CYC;
          done_nxt     = 1'b0;
          err_nxt      = 1'b0;
          unique case (pwdata[GPD_CMD_OP_LSB +: 3])
            GPD_OP_INPUT: begin
              // driver off, pin floats
              oe_nxt[pwdata[GPD_CMD_PIN_LSB +: 8]] = 1'b0;
              done_nxt = 1'b1;
            end
            GPD_OP_HIGH: begin
              // output first, level high in the same edge
              oe_nxt[pwdata[GPD_CMD_PIN_LSB +: 8]]  = 1'b1;
              out_nxt[pwdata[GPD_CMD_PIN_LSB +: 8]] = 1'b1;
              done_nxt = 1'b1;
            end
            GPD_OP_LOW: begin
              oe_nxt[pwdata[GPD_CMD_PIN_LSB +: 8]]  = 1'b1;
              out_nxt[pwdata[GPD_CMD_PIN_LSB +: 8]] = 1'b0;
              done_nxt = 1'b1;
            end
            GPD_OP_SAMP, GPD_OP_KEYH: begin
              // reads turn the pin to input by themselves
              oe_nxt[pwdata[GPD_CMD_PIN_LSB +: 8]] = 1'b0;
              state_nxt = GPD_SETTLE;
            end
            GPD_OP_KEYL: begin
              oe_nxt[pwdata[GPD_CMD_PIN_LSB +: 8]] = 1'b0;
              if (pwdata[GPD_CMD_MS_LSB +: 16] == 16'h0) begin
                // zero is outside the low active range: report no key
                err_nxt  = 1'b1;
                res_nxt  = 1'b1;
                done_nxt = 1'b1;
              end else begin
                state_nxt = GPD_SETTLE;
              end
            end
            default: begin
              // unused codes complete without touching any pin
              done_nxt = 1'b1;
            end
          endcase
        end
      end
      GPD_SETTLE: begin
        // the pad may have been driving; let the synchroniser see the
        // released level before trusting it
        settle_nxt = settle_r - 2'h1;
        if (settle_r == 2'h1) begin
          if (op_r == GPD_OP_SAMP) begin
            res_nxt   = lvl;        // single bit, 0 or 1
            done_nxt  = 1'b1;
            state_nxt = GPD_IDLE;
          end else if (!key_active(lvl, op_r == GPD_OP_KEYH)) begin
            // not pressed at the start: inactive answer at once
            res_nxt   = (op_r == GPD_OP_KEYL);
            done_nxt  = 1'b1;
            state_nxt = GPD_IDLE;
          end else if (ms_left_r == 16'h0) begin
            // zero interval is legal for the high active read
            res_nxt   = 1'b1;
            done_nxt  = 1'b1;
            state_nxt = GPD_IDLE;
          end else begin
            tick_cnt_nxt = 32'h0;
            state_nxt    = GPD_DEBOUNCE;
          end
        end
      end
      GPD_DEBOUNCE: begin
        // one bounce back to idle ends the read as not pressed
        if (!key_active(lvl, op_r == GPD_OP_KEYH)) begin
          res_nxt   = (op_r == GPD_OP_KEYL);
          done_nxt  = 1'b1;
          state_nxt = GPD_IDLE;
        end else if (ms_tick) begin
          // 1 ms tick from the system clock
          tick_cnt_nxt = 32'h0;
          ms_left_nxt  = ms_left_r - 16'h1;
          if (ms_left_r == 16'h1) begin
            // held active for the whole interval
            res_nxt   = (op_r == GPD_OP_KEYH);
            done_nxt  = 1'b1;
            state_nxt = GPD_IDLE;
          end
        end else begin
          tick_cnt_nxt = tick_cnt_r + 32'h1;
        end
      end
      default: begin
        // unused state code: back to idle rather than hang the port
        state_nxt = GPD_IDLE;
      end
    endcase
  end

  // sequencer and pin control registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_r    <= GPD_IDLE;
      oe_r       <= GPD_OE_RST;   // all pins high impedance
      out_r      <= GPD_OUT_RST;
      pin_r      <= 8'h0;
      op_r       <= GPD_OP_INPUT;
      ms_left_r  <= 16'h0;
      tick_cnt_r <= 32'h0;
      settle_r   <= 2'h0;
      res_r      <= 1'b0;
      err_r      <= 1'b0;
      done_r     <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      oe_r       <= oe_nxt;
      out_r      <= out_nxt;
      pin_r      <= pin_nxt;
      op_r       <= op_nxt;
      ms_left_r  <= ms_left_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      settle_r   <= settle_nxt;
      res_r      <= res_nxt;
      err_r      <= err_nxt;
      done_r     <= done_nxt;
    end
  end

  // apb answer, computed in the setup cycle so outputs stay registered
  always_comb begin
    prdata_nxt  = 32'h0;
    pready_nxt  = setup_phase;
    pslverr_nxt = 1'b0;
    if (setup_phase) begin
      unique case (paddr)
        GPD_CMD_OFS: begin
          // a command during a busy read is refused, not queued
          pslverr_nxt = pwrite & busy;
        end
        GPD_STAT_OFS: begin
          prdata_nxt[GPD_ST_BUSY] = busy;
          prdata_nxt[GPD_ST_RES]  = res_r;
          prdata_nxt[GPD_ST_ERR]  = err_r;
          prdata_nxt[GPD_ST_DONE] = done_r;
          pslverr_nxt = pwrite;     // read only
        end
        GPD_VIEW_OFS: begin
          prdata_nxt[7:0]        = pin_r;
          prdata_nxt[GPD_VW_OE]  = oe_r[pin_r];
          prdata_nxt[GPD_VW_OUT] = out_r[pin_r];
          prdata_nxt[GPD_VW_LVL] = lvl;
          pslverr_nxt = pwrite;     // read only
        end
        default: begin
          pslverr_nxt = 1'b1;       // unmapped address
        end
      endcase
    end
  end

  // apb answer registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      prdata_r  <= 32'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign pin_out = out_r;
  assign pin_oe  = oe_r;

endmodule

`default_nettype wire

//--- tb/gpd_pins_model.sv
// loads and keys on the pins: a pull-up and a switch on every pad
// assumes the bench sets key_lvl; a driven pad reads back its own level
`timescale 1ns/1ps
`default_nettype none
module gpd_pins_model (
  input  wire logic [255:0] pin_oe,   // driver enables from the port
  input  wire logic [255:0] pin_out,  // driven levels
  input  wire logic [255:0] key_lvl,  // switch level, 1 = open, pulled up
  output logic      [255:0] pin_in    // level seen on each pad
);
  // a released pad shows its pull-up or closed switch, never a stale level
  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & key_lvl);
  end
endmodule
`default_nettype wire

//--- tb/gpd_port_sva.sv
// checker for the pin port: apb timing and pin direction updates
// assumes binding onto gpd_port and watches only its ports
`timescale 1ns/1ps
`default_nettype none
module gpd_port_sva
  import gpd_pkg::*;
#(
  parameter int MS_CYCLES = 20  // cycles per ms
) (
  input wire logic         sys_clk,
  input wire logic         resetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  pwdata,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic [255:0] pin_in,
  input wire logic [255:0] pin_out,
  input wire logic [255:0] pin_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [7:0] pin_q;  // pin of the previous cycle's command word
  // one cycle late, so it names the pin of the taken command
  always_ff @(posedge sys_clk) begin
    pin_q <= pwdata[7:0];
  end
  // setup cycle of a command write with a given op
  sequence cmd_take(logic [2:0] op);
    psel && !penable && pwrite && paddr == GPD_CMD_OFS && pwdata[10:8] == op;
  endsequence
  ready_once_a: assert property (pready |=> !pready) else $error("ready held");
  setup_ready_a: assert property (psel && !penable |=> pready) else $error("no ready");
  read_idle_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("idle bus busy");
  write_refuse_a: assert property (psel && !penable && pwrite && paddr != GPD_CMD_OFS
    |=> pslverr) else $error("bad write taken");
  read_unmapped_a: assert property (psel && !penable && !pwrite && paddr > GPD_VIEW_OFS
    |=> pslverr && prdata == 32'h0) else $error("unmapped read");
  reset_hiz_a: assert property ($rose(resetn) |-> pin_oe == 256'h0)
    else $error("pin driven after reset");
  drive_high_a: assert property (cmd_take(GPD_OP_HIGH)
    |=> pslverr || (pin_oe[pin_q] && pin_out[pin_q])) else $error("no high");
  drive_low_a: assert property (cmd_take(GPD_OP_LOW)
    |=> pslverr || (pin_oe[pin_q] && !pin_out[pin_q])) else $error("no low");
  input_sel_a: assert property (cmd_take(GPD_OP_INPUT)
    |=> pslverr || !pin_oe[pin_q]) else $error("input still driven");
  sample_in_a: assert property (cmd_take(GPD_OP_SAMP)
    |=> pslverr || !pin_oe[pin_q]) else $error("sample still driven");
endmodule
`default_nettype wire

//--- tb/tb_gpio_pins_with_debounce.sv
// self-checking bench for the debounced pin port over apb
// assumes gpd_port, gpd_pins_model and gpd_port_sva are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %0t got %h want %h", $time, g, e); end end
module tb_gpio_pins_with_debounce;
  import gpd_pkg::*;
  localparam int MS = 20;               // short ms keeps intervals brief
  logic         sys_clk = 1'b0;         // system clock
  logic         resetn  = 1'b0;         // sync reset, active low
  logic         psel    = 1'b0;         // apb request
  logic         penable = 1'b0;
  logic         pwrite  = 1'b0;
  logic [11:0]  paddr   = 12'h000;
  logic [31:0]  pwdata  = 32'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [255:0] pin_in;
  logic [255:0] pin_out;
  logic [255:0] pin_oe;
  logic [255:0] key_lvl = {256{1'b1}};  // all switches open
  logic [31:0]  rd;                     // last read word
  logic         er;                     // last error response
  int           mismatches = 0;
  int           checked    = 0;
  int           cyc        = 0;         // free running cycle count
  gpd_port #(.MS_CYCLES(MS)) dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe));
  gpd_pins_model u_pins (.pin_oe(pin_oe), .pin_out(pin_out), .key_lvl(key_lvl),
    .pin_in(pin_in));
  // 200 mhz clock
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;
  // one apb transfer; waits up to 50 cycles for pready, then counts a mismatch
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (n >= 50) begin mismatches++; $display("BAD %0t no ready", $time); end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task cmd(input logic [7:0] p, input logic [2:0] op, input logic [15:0] ms);
    apb(1'b1, GPD_CMD_OFS, {ms, 5'h00, op, p});
  endtask
  // poll status until the command is done
  task done_wait;
    int n;
    n = 0;
    do begin apb(1'b0, GPD_STAT_OFS, 32'h0); n++; end
    while (rd[GPD_ST_DONE] !== 1'b1 && n < 200);
    `CHK(rd[GPD_ST_DONE], 1'b1)
  endtask
  task t_reset;
    `CHK(pin_oe, 256'h0)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(1'b0, GPD_CMD_OFS, 32'h0);
    `CHK({er, rd}, 33'h0)
    apb(1'b1, GPD_STAT_OFS, 32'h1);
    `CHK(er, 1'b1)
    $display("test reset done");
  endtask
  // both ends of the index range, every direction op
  task t_drive;
    logic [7:0] p;
    for (int k = 0; k < 2; k++) begin
      p = k ? 8'hff : 8'h00;
      cmd(p, GPD_OP_HIGH, 16'h0000);
      `CHK({pin_oe[p], pin_out[p]}, 2'b11)
      `CHK(pin_oe & ~(256'h1 << p), 256'h0)
      apb(1'b0, GPD_VIEW_OFS, 32'h0);
      `CHK(rd[10:0], {3'b111, p})
      cmd(p, GPD_OP_LOW, 16'h0000);
      `CHK({pin_oe[p], pin_out[p]}, 2'b10)
      cmd(p, GPD_OP_INPUT, 16'h0000);
      `CHK(pin_oe[p], 1'b0)
    end
    // an unused op code completes and leaves the pin alone
    cmd(8'h10, GPD_OP_HIGH, 16'h0000);
    cmd(8'h10, 3'h6, 16'h0000);
    `CHK({pin_oe[16], pin_out[16]}, 2'b11)
    apb(1'b0, GPD_STAT_OFS, 32'h0);
    `CHK({rd[GPD_ST_DONE], rd[GPD_ST_BUSY]}, 2'b10)
    cmd(8'h10, GPD_OP_INPUT, 16'h0000);
    `CHK(pin_oe, 256'h0)
    $display("test drive done");
  endtask
  // sampling a driven pin must release it and read the switch
  task t_sample;
    cmd(8'h07, GPD_OP_HIGH, 16'h0000);
    key_lvl[7] <= 1'b0;
    cmd(8'h07, GPD_OP_SAMP, 16'h0000);
    `CHK(pin_oe[7], 1'b0)
    done_wait;
    `CHK(rd[GPD_ST_RES], 1'b0)
    key_lvl[7] <= 1'b1;
    cmd(8'h07, GPD_OP_SAMP, 16'h0000);
    done_wait;
    `CHK(rd[GPD_ST_RES], 1'b1)
    $display("test sample done");
  endtask
  task t_keyl;
    int t0;
    key_lvl[3] <= 1'b0;
    t0 = cyc;
    cmd(8'h03, GPD_OP_KEYL, 16'd10);
    done_wait;
    `CHK({rd[GPD_ST_ERR], rd[GPD_ST_RES]}, 2'b00)
    `CHK((cyc - t0 >= 10 * MS) && (cyc - t0 < 11 * MS), 1'b1)
    cmd(8'h03, GPD_OP_KEYL, 16'd10);
    repeat (40) @(posedge sys_clk);
    apb(1'b0, GPD_STAT_OFS, 32'h0);
    `CHK({rd[GPD_ST_BUSY], rd[GPD_ST_DONE]}, 2'b10)
    key_lvl[3] <= 1'b1;
    cmd(8'h03, GPD_OP_KEYL, 16'd10);
    `CHK(er, 1'b1)
    key_lvl[3] <= 1'b0;
    done_wait;
    `CHK(rd[GPD_ST_RES], 1'b1)
    key_lvl[3] <= 1'b1;
    cmd(8'h03, GPD_OP_KEYL, 16'hffff);
    done_wait;
    `CHK({rd[GPD_ST_ERR], rd[GPD_ST_RES]}, 2'b01)
    cmd(8'h03, GPD_OP_KEYL, 16'h0000);
    done_wait;
    `CHK(rd[GPD_ST_ERR], 1'b1)
    $display("test key low done");
  endtask
  task t_keyh;
    cmd(8'hc8, GPD_OP_KEYH, 16'd1);
    done_wait;
    `CHK({rd[GPD_ST_ERR], rd[GPD_ST_RES]}, 2'b01)
    cmd(8'hc8, GPD_OP_KEYH, 16'h0000);
    done_wait;
    `CHK({rd[GPD_ST_ERR], rd[GPD_ST_RES]}, 2'b01)
    key_lvl[200] <= 1'b0;
    cmd(8'hc8, GPD_OP_KEYH, 16'hffff);
    done_wait;
    `CHK({rd[GPD_ST_ERR], rd[GPD_ST_RES]}, 2'b00)
    $display("test key high done");
  endtask
  task close_out;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // a hang ends the run as a failure
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    $display("BAD %0t timeout", $time);
    close_out;
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset;
    t_drive;
    t_sample;
    t_keyl;
    t_keyh;
    close_out;
  end
endmodule
bind gpd_port gpd_port_sva #(.MS_CYCLES(MS_CYCLES)) u_sva (.sys_clk(sys_clk),
  .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire
